// [rtl/chan_cfg_pkg.sv]
package chan_cfg_pkg;

  // ************************************************************
  // Word and address widths.
  // ************************************************************
  localparam int DATA_W = 16;
  localparam int ADDR_W = 10;
  localparam int RES_BITS_DEF = 12;
  localparam int RES_BITS_ALT = 10;

  // ************************************************************
  // Default register numbers for the module's position.
  // ************************************************************
  localparam int IN_BASE_DEF = 1;
  localparam int OUT_BASE_DEF = 101;
  localparam int PAR_BASE_DEF = 214;

  // ************************************************************
  // Field offsets from a channel's parameter base.
  // ************************************************************
  localparam int OFS_RANGE = 0;
  localparam int OFS_UNIT = 1;
  localparam int OFS_LOW = 2;
  localparam int OFS_HIGH = 3;
  localparam int OFS_FB_MODE = 4;
  localparam int OFS_FB_VAL = 5;
  localparam int IN_STRIDE = 4;
  localparam int OUT_WORDS = 6;
  localparam int MAX_IN = 2;

  // ************************************************************
  // Range codes.
  // ************************************************************
  localparam logic [15:0] RANGE_UNUSED = 16'h0000;
  localparam logic [15:0] RANGE_0_20MA = 16'h0001;
  localparam logic [15:0] RANGE_4_20MA = 16'h0002;
  localparam logic [15:0] RANGE_0_10V = 16'h0003;
  localparam logic [15:0] RANGE_BIP_10V = 16'h0004;
  localparam logic [15:0] RANGE_TC_K = 16'h0005;
  localparam logic [15:0] RANGE_TC_J = 16'h0006;
  localparam logic [15:0] RANGE_TC_T = 16'h0007;
  localparam logic [15:0] RANGE_RTD_FIRST = 16'h0008;
  localparam logic [15:0] RANGE_RTD_LAST = 16'h000B;
  localparam logic [15:0] RANGE_RESERVED = 16'h000C;
  localparam logic [15:0] RANGE_NTC = 16'h000D;
  localparam logic [15:0] RANGE_PTC = 16'h000E;

  // ************************************************************
  // Unit codes.
  // ************************************************************
  localparam logic [15:0] UNIT_NORMAL = 16'h0000;
  localparam logic [15:0] UNIT_CUSTOM = 16'h0001;
  localparam logic [15:0] UNIT_CELSIUS = 16'h0002;
  localparam logic [15:0] UNIT_FAHR = 16'h0003;
  localparam logic [15:0] UNIT_OHMS = 16'h0004;

  // ************************************************************
  // Fallback mode codes and reset values.
  // ************************************************************
  localparam logic [15:0] FB_HOLD = 16'h0000;
  localparam logic [15:0] FB_APPLY = 16'h0001;
  localparam logic [15:0] RST_RANGE = 16'h0000;
  localparam logic [15:0] RST_UNIT = 16'h0001;
  localparam logic [15:0] RST_LOW = 16'h0000;
  localparam logic [15:0] RST_HIGH = 16'h7FFF;
  localparam logic [15:0] RST_FB_MODE = 16'h0001;
  localparam logic [15:0] RST_FB_VAL = 16'h0000;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam int NORM_BITS = 15;

endpackage

// [rtl/analog_channel_config_fallback.sv]
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// (R1) Register numbers are fixed offsets from bases set by module position.
// (R2) Only the input channels and output fitted to the variant are decoded.
// (R3) Range word selects signal type; code zero means the channel is unused.
// (R4) Unit word selects normal, customized, tenth degree or ohm scaling.
// (R5) Minimum and maximum words act only when unit selects customized.
// (R6) Fallback mode zero holds the output, one applies the fallback value.
// (R7) On a communication error each output takes its fallback behaviour.
// (R8) Input values read as 16-bit words in channel order from input base.
// (R9) Master commands the output by writing one word at the output base.
// (R10) Second input channel repeats the first channel's four fields.
// (R11) Customized limits reset to zero and 7FFF, used only when unit is one.
// (R12) Resolution is 12 or 10 bits; mixing types only where allowed.
// (R13) Fallback holds until communication returns and a new command arrives.
module analog_channel_config_fallback #(
  parameter int IN_BASE = chan_cfg_pkg::IN_BASE_DEF,
  parameter int OUT_BASE = chan_cfg_pkg::OUT_BASE_DEF,
  parameter int PAR_BASE = chan_cfg_pkg::PAR_BASE_DEF,
  parameter int NUM_IN = 2,
  parameter bit HAS_OUT = 1'b1,
  parameter bit MIX_OK = 1'b1,
  parameter int RES_BITS = chan_cfg_pkg::RES_BITS_DEF
) (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic [9:0] REG_ADDR_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [15:0] REG_WDATA_IN,
  output logic [15:0] REG_RDATA_OUT,
  output logic REG_ACK_OUT,
  input wire logic COMM_ERR_IN,
  input wire logic [RES_BITS-1:0] FIRST_ANALOG_CHANNEL_IN,
  input wire logic [RES_BITS-1:0] SECOND_ANALOG_CHANNEL_IN,
  output logic [15:0] ANALOG_OUT_VALUE_OUT,
  output logic FALLBACK_ACTIVE_OUT
);

  // ************************************************************
  // Helpers.
  // ************************************************************

  // Scales a raw conversion into the word the master reads.
  function automatic logic [15:0] scale_in(input logic [RES_BITS-1:0] raw,
      input logic [15:0] rng, input logic [15:0] unit,
      input logic [15:0] lo, input logic [15:0] hi);
    logic [31:0] prod;
    logic [15:0] r16;
    prod = (32'(hi) - 32'(lo)) * 32'(raw);
    r16 = 16'(raw);
    if (rng == chan_cfg_pkg::RANGE_UNUSED) begin
      scale_in = 16'h0000; // R3
    end else if (unit == chan_cfg_pkg::UNIT_CUSTOM) begin
      scale_in = lo + 16'(prod >> RES_BITS); // R5
    end else if (unit == chan_cfg_pkg::UNIT_NORMAL) begin
      scale_in = 16'(r16 << (chan_cfg_pkg::NORM_BITS - RES_BITS)); // R4
    end else begin
      scale_in = r16; // R4
    end
  endfunction

  // True when the address hits register number base plus offset.
  function automatic logic hit(input logic [9:0] a, input int base,
      input int ofs);
    hit = (a == 10'(base + ofs));
  endfunction

  // ************************************************************
  // Communication error synchroniser.
  // ************************************************************
  logic err_meta_r;
  logic err_s_r;

  // Two flip-flops bring the error pin into the clock domain.
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      err_meta_r <= 1'b0;
      err_s_r <= 1'b0;
    end else begin
      err_meta_r <= COMM_ERR_IN;
      err_s_r <= err_meta_r;
    end
  end

  // ************************************************************
  // Configuration registers and command word.
  // ************************************************************
  logic [15:0] cfg_in_r [chan_cfg_pkg::MAX_IN][chan_cfg_pkg::IN_STRIDE];
  logic [15:0] cfg_in_nxt [chan_cfg_pkg::MAX_IN][chan_cfg_pkg::IN_STRIDE];
  logic [15:0] cfg_out_r [chan_cfg_pkg::OUT_WORDS];
  logic [15:0] cfg_out_nxt [chan_cfg_pkg::OUT_WORDS];
  logic [15:0] cmd_r;
  logic [15:0] cmd_nxt;
  logic cmd_wr;
  int out_par;

  assign out_par = PAR_BASE + chan_cfg_pkg::IN_STRIDE * NUM_IN;
  assign cmd_wr = HAS_OUT && REG_WR_IN && hit(REG_ADDR_IN, OUT_BASE, 0); // R9

  // Decodes writes to the fields that this variant fits.
  always_comb begin
    cfg_in_nxt = cfg_in_r;
    cfg_out_nxt = cfg_out_r;
    cmd_nxt = cmd_r;
    if (REG_WR_IN) begin
      for (int i = 0; i < NUM_IN; i++) begin // R2
        for (int k = 0; k < chan_cfg_pkg::IN_STRIDE; k++) begin
          if (hit(REG_ADDR_IN, PAR_BASE, chan_cfg_pkg::IN_STRIDE*i + k)) begin
            cfg_in_nxt[i][k] = REG_WDATA_IN; // R10 R1
          end
        end
      end
      for (int k = 0; k < chan_cfg_pkg::OUT_WORDS; k++) begin
        if (HAS_OUT && hit(REG_ADDR_IN, out_par, k)) begin
          cfg_out_nxt[k] = REG_WDATA_IN; // R6 R2
        end
      end
    end
    if (cmd_wr) begin
      cmd_nxt = REG_WDATA_IN;
    end
  end

  // Registers the configuration with the documented defaults.
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      for (int i = 0; i < chan_cfg_pkg::MAX_IN; i++) begin
        cfg_in_r[i][chan_cfg_pkg::OFS_RANGE] <= chan_cfg_pkg::RST_RANGE;
        cfg_in_r[i][chan_cfg_pkg::OFS_UNIT] <= chan_cfg_pkg::RST_UNIT;
        cfg_in_r[i][chan_cfg_pkg::OFS_LOW] <= chan_cfg_pkg::RST_LOW;
        cfg_in_r[i][chan_cfg_pkg::OFS_HIGH] <= chan_cfg_pkg::RST_HIGH;
      end
      cfg_out_r[chan_cfg_pkg::OFS_RANGE] <= chan_cfg_pkg::RST_RANGE;
      cfg_out_r[chan_cfg_pkg::OFS_UNIT] <= chan_cfg_pkg::RST_UNIT;
      cfg_out_r[chan_cfg_pkg::OFS_LOW] <= chan_cfg_pkg::RST_LOW; // R11
      cfg_out_r[chan_cfg_pkg::OFS_HIGH] <= chan_cfg_pkg::RST_HIGH; // R11
      cfg_out_r[chan_cfg_pkg::OFS_FB_MODE] <= chan_cfg_pkg::RST_FB_MODE;
      cfg_out_r[chan_cfg_pkg::OFS_FB_VAL] <= chan_cfg_pkg::RST_FB_VAL;
      cmd_r <= chan_cfg_pkg::RST_WORD;
    end else begin
      cfg_in_r <= cfg_in_nxt;
      cfg_out_r <= cfg_out_nxt;
      cmd_r <= cmd_nxt;
    end
  end

  // ************************************************************
  // Input values.
  // ************************************************************
  logic [15:0] in_val_r [chan_cfg_pkg::MAX_IN];
  logic [15:0] in_val_nxt [chan_cfg_pkg::MAX_IN];
  logic [15:0] rng1;

  // Without mixing the second channel follows the first one's type.
  assign rng1 = MIX_OK ? cfg_in_r[1][chan_cfg_pkg::OFS_RANGE]
                       : cfg_in_r[0][chan_cfg_pkg::OFS_RANGE]; // R12

  // Scales each conversion by its channel's range and unit.
  always_comb begin
    in_val_nxt[0] = scale_in(FIRST_ANALOG_CHANNEL_IN,
        cfg_in_r[0][chan_cfg_pkg::OFS_RANGE],
        cfg_in_r[0][chan_cfg_pkg::OFS_UNIT],
        cfg_in_r[0][chan_cfg_pkg::OFS_LOW],
        cfg_in_r[0][chan_cfg_pkg::OFS_HIGH]); // R8
    in_val_nxt[1] = scale_in(SECOND_ANALOG_CHANNEL_IN, rng1,
        cfg_in_r[1][chan_cfg_pkg::OFS_UNIT],
        cfg_in_r[1][chan_cfg_pkg::OFS_LOW],
        cfg_in_r[1][chan_cfg_pkg::OFS_HIGH]); // R8
  end

  // Registers the scaled input words.
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      in_val_r[0] <= chan_cfg_pkg::RST_WORD;
      in_val_r[1] <= chan_cfg_pkg::RST_WORD;
    end else begin
      in_val_r <= in_val_nxt;
    end
  end

  // ************************************************************
  // Register reads.
  // ************************************************************
  logic [15:0] rdata_nxt;
  logic ack_nxt;

  // Returns the addressed word; unmapped numbers read as zero.
  always_comb begin
    rdata_nxt = 16'h0000;
    ack_nxt = REG_RD_IN || REG_WR_IN;
    if (REG_RD_IN) begin
      for (int i = 0; i < NUM_IN; i++) begin
        if (hit(REG_ADDR_IN, IN_BASE, i)) begin
          rdata_nxt = in_val_r[i]; // R8
        end
        for (int k = 0; k < chan_cfg_pkg::IN_STRIDE; k++) begin
          if (hit(REG_ADDR_IN, PAR_BASE, chan_cfg_pkg::IN_STRIDE*i + k)) begin
            rdata_nxt = cfg_in_r[i][k];
          end
        end
      end
      for (int k = 0; k < chan_cfg_pkg::OUT_WORDS; k++) begin
        if (HAS_OUT && hit(REG_ADDR_IN, out_par, k)) begin
          rdata_nxt = cfg_out_r[k];
        end
      end
    end
  end

  // Registers the read answer and its acknowledge.
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      REG_RDATA_OUT <= 16'h0000;
      REG_ACK_OUT <= 1'b0;
    end else begin
      REG_RDATA_OUT <= rdata_nxt;
      REG_ACK_OUT <= ack_nxt;
    end
  end

  // ************************************************************
  // Output drive and fallback.
  // ************************************************************
  logic fb_active_r;
  logic fb_active_nxt;
  logic [15:0] out_nxt;
  logic [15:0] cmd_eff;
  logic [15:0] o_lo;
  logic [15:0] o_hi;

  assign o_lo = cfg_out_r[chan_cfg_pkg::OFS_LOW];
  assign o_hi = cfg_out_r[chan_cfg_pkg::OFS_HIGH];

  // Chooses the commanded, held or fallback value for the output.
  always_comb begin
    cmd_eff = cmd_r;
    if (cfg_out_r[chan_cfg_pkg::OFS_UNIT] == chan_cfg_pkg::UNIT_CUSTOM) begin
      if (cmd_r < o_lo) begin
        cmd_eff = o_lo; // R5 R11
      end else if (cmd_r > o_hi) begin
        cmd_eff = o_hi; // R5 R11
      end
    end
    fb_active_nxt = fb_active_r;
    if (err_s_r && HAS_OUT) begin
      fb_active_nxt = 1'b1; // R7
    end else if (cmd_wr) begin
      fb_active_nxt = 1'b0; // R13
    end
    if (cfg_out_r[chan_cfg_pkg::OFS_RANGE] == chan_cfg_pkg::RANGE_UNUSED) begin
      out_nxt = 16'h0000; // R3
    end else if (fb_active_r) begin
      if (cfg_out_r[chan_cfg_pkg::OFS_FB_MODE] == chan_cfg_pkg::FB_HOLD) begin
        out_nxt = ANALOG_OUT_VALUE_OUT; // R6
      end else begin
        out_nxt = cfg_out_r[chan_cfg_pkg::OFS_FB_VAL]; // R6
      end
    end else begin
      out_nxt = cmd_eff;
    end
  end

  // Registers the output word and fallback state.
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      fb_active_r <= 1'b0;
      ANALOG_OUT_VALUE_OUT <= 16'h0000;
    end else begin
      fb_active_r <= fb_active_nxt;
      ANALOG_OUT_VALUE_OUT <= out_nxt;
    end
  end

  assign FALLBACK_ACTIVE_OUT = fb_active_r;

  // ************************************************************
  // Assertions.
  // ************************************************************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  a_ack_follows_req: assert property ( // R1
      (REG_RD_IN || REG_WR_IN) |=> REG_ACK_OUT)
    else $error("Access not acknowledged next cycle.");
  a_unused_out_zero: assert property ( // R3
      cfg_out_r[0] == chan_cfg_pkg::RANGE_UNUSED |=> ANALOG_OUT_VALUE_OUT == 0)
    else $error("Unused output not driven to zero.");
  a_custom_clamp: assert property ( // R5
      !fb_active_r && cfg_out_r[1] == 16'h0001
      && cfg_out_r[0] != 0 && o_lo <= o_hi
      |=> ANALOG_OUT_VALUE_OUT >= $past(o_lo)
      && ANALOG_OUT_VALUE_OUT <= $past(o_hi))
    else $error("Customized output outside limits.");
  a_fb_apply: assert property (fb_active_r && cfg_out_r[4] == 16'h0001 // R6
      && cfg_out_r[0] != 0 |=> ANALOG_OUT_VALUE_OUT == $past(cfg_out_r[5]))
    else $error("Fallback value not applied.");
  a_fb_hold: assert property (fb_active_r && cfg_out_r[4] == 16'h0000 // R6
      && cfg_out_r[0] != 0 |=> $stable(ANALOG_OUT_VALUE_OUT))
    else $error("Held output changed during fallback.");
  a_err_enters_fb: assert property (HAS_OUT && $rose(err_s_r) // R7
      |=> fb_active_r)
    else $error("Error did not enter fallback.");
  a_fb_keeps: assert property (fb_active_r && !(cmd_wr && !err_s_r) // R13
      |=> fb_active_r)
    else $error("Fallback left without a new command.");
  a_input_read: assert property (NUM_IN > 0 && REG_RD_IN // R8
      && REG_ADDR_IN == 10'(IN_BASE) |=> REG_RDATA_OUT == $past(in_val_r[0]))
    else $error("Input word read back wrong.");
  a_normal_scale: assert property (NUM_IN > 0 && cfg_in_r[0][1] == 0 // R4
      && cfg_in_r[0][0] != 0
      |=> in_val_r[0] == 16'($past(FIRST_ANALOG_CHANNEL_IN)
      << (15 - RES_BITS)))
    else $error("Normal scaling wrong.");

endmodule
`default_nettype wire

// [tb/reg_master.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// Field bus master model driving the register port.
// ****************************************************
module reg_master (
  input wire logic clk_in,
  input wire logic ack_in,
  input wire logic [15:0] rdata_in,
  output logic [9:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [15:0] wdata_out
);
  int late_cnt = 0;
  // Idle lines start quiet and strobes low.
  initial begin
    addr_out = 10'h000;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 16'h0000;
  end
  // One word per access; the strobe is taken at one edge only.
  task automatic xfer(input bit w, input logic [9:0] a,
                      input logic [15:0] d);
    int n;
    n = 0;
    addr_out <= a;
    wdata_out <= d;
    wr_out <= w;
    rd_out <= !w;
    @(posedge clk_in);
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack_in !== 1'b1 && n < 8);
    if (n >= 8) late_cnt++;
    // Released lines show the inverse for one idle cycle before the next.
    addr_out <= ~a;
    wdata_out <= ~d;
    @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// [tb/analog_channel_config_fallback_test.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// Self-checking bench for the channel configuration block.
// ****************************************************
module analog_channel_config_fallback_test;
  localparam int P = chan_cfg_pkg::PAR_BASE_DEF;
  localparam int Q = chan_cfg_pkg::OUT_BASE_DEF;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic err = 1'b0;
  logic [11:0] raw0 = 12'h000;
  logic [11:0] raw1 = 12'h000;
  logic [9:0] addr;
  logic wr, rd, ack, fb;
  logic [15:0] wdata, rdata, aout;
  int miscompares = 0;
  int n_tests = 0;
  logic [16:0] expq[$];
  logic [15:0] rst_tab[14] = '{16'h0000, 16'h0001, 16'h0000, 16'h7FFF,
    16'h0000, 16'h0001, 16'h0000, 16'h7FFF, 16'h0000, 16'h0001,
    16'h0000, 16'h7FFF, 16'h0001, 16'h0000};
  logic [15:0] lo, hi, c, v;
  logic [31:0] t;
  // The clock toggles every half period of 2.5 ns.
  initial forever #2.5 clk = ~clk;
  analog_channel_config_fallback dut (.CLK_IN(clk), .SYS_RST_IN(rst),
    .REG_ADDR_IN(addr), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .REG_ACK_OUT(ack),
    .COMM_ERR_IN(err), .FIRST_ANALOG_CHANNEL_IN(raw0),
    .SECOND_ANALOG_CHANNEL_IN(raw1), .ANALOG_OUT_VALUE_OUT(aout),
    .FALLBACK_ACTIVE_OUT(fb));
  reg_master mst (.clk_in(clk), .ack_in(ack), .rdata_in(rdata),
    .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata));
  // ****************************************************
  // Comparison, access and closing tasks.
  // ****************************************************
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    n_tests++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, s);
      miscompares++;
    end
  endtask
  task automatic wrw(int a, logic [15:0] d);
    expq.push_back({1'b0, 16'h0000});
    mst.xfer(1'b1, a[9:0], d);
  endtask
  task automatic rdw(int a, logic [15:0] e);
    expq.push_back({1'b1, e});
    mst.xfer(1'b0, a[9:0], 16'h0000);
  endtask
  task automatic wait_fb(logic want);
    int n;
    n = 0;
    while (fb !== want && n < 8) begin
      @(posedge clk);
      n++;
    end
    #1 chk("fallback_active", {15'h0000, want}, {15'h0000, fb});
    if (fb !== want) begin
      complete_run();
    end
  endtask
  task automatic complete_run();
    miscompares += mst.late_cnt + expq.size();
    if (miscompares == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Each acknowledge retires the oldest noted access.
  always @(posedge clk) begin
    if (ack === 1'b1) begin
      if (expq.size() == 0) begin
        chk("ack_count", 16'h0000, 16'h0001);
      end else if (expq[0][16]) begin
        chk("rdata", expq[0][15:0], rdata);
        void'(expq.pop_front());
      end else begin
        void'(expq.pop_front());
      end
    end
  end
  // ****************************************************
  // Main sequence.
  // ****************************************************
  initial begin
    void'($urandom(51543));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk("out_reset", 16'h0000, aout);
    // Reset values, write-only command and unfitted numbers.
    for (int i = 0; i < 14; i++) rdw(P + i, rst_tab[i]);
    rdw(Q, 16'h0000);
    rdw(P + 14, 16'h0000);
    rdw(300, 16'h0000);
    for (int i = 0; i < 14; i++) begin
      c = 16'($urandom);
      wrw(P + i, c);
      rdw(P + i, c);
    end
    // Input scaling for both channels.
    raw0 <= 12'($urandom);
    raw1 <= 12'($urandom);
    lo = 16'($urandom_range(0, 16'h3FFF));
    hi = lo + 16'($urandom_range(1, 16'h3FFF));
    wrw(P, 16'h0003);
    wrw(P + 1, 16'h0000);
    wrw(P + 4, 16'h0002);
    wrw(P + 5, 16'h0001);
    wrw(P + 6, lo);
    wrw(P + 7, hi);
    t = 32'(hi - lo) * 32'(raw1);
    rdw(1, {1'b0, raw0, 3'h0});
    rdw(2, lo + t[27:12]);
    wrw(1, 16'hFFFF);
    rdw(1, {1'b0, raw0, 3'h0});
    for (int r = 0; r < 15; r++) begin
      if (r != 12) begin
        wrw(P, r[15:0]);
        rdw(1, (r == 0) ? 16'h0000 : {1'b0, raw0, 3'h0});
      end
    end
    for (int u = 2; u < 5; u++) begin
      wrw(P + 1, u[15:0]);
      rdw(1, {4'h0, raw0});
    end
    // Output command, plain and clamped.
    wrw(P + 8, 16'h0003);
    wrw(P + 9, 16'h0000);
    c = 16'($urandom);
    wrw(Q, c);
    #1 chk("out_cmd", c, aout);
    wrw(P + 9, 16'h0001);
    wrw(P + 10, lo);
    wrw(P + 11, hi);
    wrw(Q, hi + 16'h0001);
    #1 chk("out_clamp_hi", hi, aout);
    wrw(Q, (lo == 0) ? 16'h0000 : lo - 16'h0001);
    #1 chk("out_clamp_lo", lo, aout);
    wrw(P + 9, 16'h0000);
    // Fallback applied, kept, then left on a fresh command.
    v = 16'($urandom);
    wrw(P + 12, 16'h0001);
    wrw(P + 13, v);
    err <= 1'b1;
    wait_fb(1'b1);
    @(posedge clk);
    #1 chk("out_fallback", v, aout);
    c = 16'($urandom);
    wrw(Q, c);
    #1 chk("fb_during_err", 16'h0001, {15'h0000, fb});
    err <= 1'b0;
    repeat (5) @(posedge clk);
    #1 chk("out_kept", v, aout);
    wrw(Q, c);
    @(posedge clk);
    wait_fb(1'b0);
    chk("out_resumed", c, aout);
    // Hold mode keeps the present output.
    wrw(P + 12, 16'h0000);
    err <= 1'b1;
    wait_fb(1'b1);
    repeat (3) @(posedge clk);
    #1 chk("out_hold", c, aout);
    err <= 1'b0;
    repeat (4) @(posedge clk);
    complete_run();
  end
endmodule
`default_nettype wire
